// ### core/spc_pin_ctrl.sv
// System pin control: reset pin, watchdog reset pulse, drive protection, external
// interrupts, clock output pin, boot strap and flag, and the output-disable test state.
// Assumes one system clock; all pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module spc_pin_ctrl import spc_pkg::*; #(
	parameter int PC_WIDTH = 16,
	parameter int DOG_CYCLES = DOG_PULSE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sysResetNPinIn,
	output logic sysResetNPinOut,
	output logic sysResetNPinOeN,
	input wire logic dogOverflow,
	output logic coreHalt,
	input wire logic instrStep,
	output logic [PC_WIDTH-1:0] programCounter,
	input wire logic driveProtectAIn,
	input wire logic driveProtectBIn,
	input wire logic protectAClear,
	input wire logic protectBClear,
	output logic protectAIrq,
	output logic protectBIrq,
	output logic pwmAHiZ,
	output logic pwmBHiZ,
	input wire logic extIrqOneIn,
	input wire logic extIrqTwoIn,
	output logic extIrqOne,
	output logic extIrqTwo,
	output logic convStart,
	output logic extIrqOneLevel,
	output logic extIrqTwoLevel,
	input wire logic irqCfgWrEn,
	input wire logic [2:0] irqCfgWrData,
	output logic [2:0] irqCfg,
	input wire logic sysCtrlWrEn,
	input wire logic [15:0] sysCtrlWrData,
	output logic [15:0] sysCtrlStatus,
	input wire logic sysCtrlTwoWrEn,
	input wire logic [15:0] sysCtrlTwoWrData,
	output logic [15:0] sysCtrlStatusTwo,
	input wire logic cpuClockIn,
	input wire logic dogTimerClockIn,
	input wire logic clkPinIn,
	output logic cpuClockOut,
	output logic cpuClockOeN,
	input wire logic clkPinWrEn,
	input wire logic [2:0] clkPinWrData,
	output logic [2:0] clkPinCfg,
	output logic clkPinLevel,
	input wire logic bootEnPinIn,
	output logic extFlagOut,
	output logic extFlagOeN,
	input wire logic flagWrEn,
	input wire logic flagWrData,
	input wire logic outputDisablePinIn,
	input wire logic trstIn,
	input wire logic emulatorPinZeroIn,
	output logic outputDisable,
	output logic xtalOutOeN
);
	localparam int DOG_W = $clog2(DOG_CYCLES + 1);
	localparam logic [DOG_W-1:0] DOG_LOAD = DOG_W'(DOG_CYCLES);
	localparam logic [1:0] SETTLE_LAST = 2'(SYNC_SETTLE_CYCLES - 1);

	// Refuse widths and counts the logic cannot serve.
	if (PC_WIDTH < 1 || DOG_CYCLES < 1) begin : g_bad_param
		$error("spc_pin_ctrl: PC_WIDTH and DOG_CYCLES must be at least 1");
	end

	logic [PIN_COUNT-1:0] pinRaw;
	logic [PIN_COUNT-1:0] pinLevel;
	logic [PIN_COUNT-1:0] pinRise;
	logic [PIN_COUNT-1:0] pinFall;
	spc_phase_type phase;
	spc_phase_type next_phase;
	logic [1:0] settleCount;
	logic [DOG_W-1:0] dogCount;
	logic dogActive;
	logic coreResetReq;
	logic coreRun;
	logic holdReset;
	logic protectAFlag;
	logic protectBFlag;
	logic edgeOne;
	logic edgeTwo;
	logic flagValue;

	// Every asynchronous pin goes through the same synchroniser before any decision.
	assign pinRaw = {clkPinIn, emulatorPinZeroIn, trstIn, outputDisablePinIn, bootEnPinIn,
		extIrqTwoIn, extIrqOneIn, driveProtectBIn, driveProtectAIn, sysResetNPinIn};

	spc_pin_sync #(
		.WIDTH(PIN_COUNT),
		.IDLE(PIN_IDLE)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pinIn(pinRaw),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);
	// The core is held while the pin is low or our own watchdog pulse runs.
	assign dogActive = (dogCount != '0);
	assign coreResetReq = ~pinLevel[PIN_RESET] | dogActive;
	assign coreRun = (phase == PH_RUN);
	assign holdReset = (phase == PH_HOLD);
	assign coreHalt = ~coreRun;
	// Watchdog pulse; a second overflow during a running pulse does not stretch it.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dogCount <= '0;
		end else if (dogActive) begin
			dogCount <= dogCount - DOG_W'(1);
		end else if (dogOverflow) begin
			dogCount <= DOG_LOAD;
		end
	end
	// The reset pin is open drain: only ever pulled low, and released in the test state.
	assign sysResetNPinOut = 1'b0;
	assign sysResetNPinOeN = ~dogActive | outputDisable;
	// Phase sequencing; SAMPLE is the last reset cycle, so straps see settled pins.
	always_comb begin
		next_phase = phase;
		case (phase)
			PH_HOLD: begin
				if (!coreResetReq && settleCount == SETTLE_LAST) begin
					next_phase = PH_SAMPLE;
				end
			end
			PH_SAMPLE: begin
				next_phase = coreResetReq ? PH_HOLD : PH_RUN;
			end
			PH_RUN: begin
				if (coreResetReq) begin
					next_phase = PH_HOLD;
				end
			end
			default: begin
				next_phase = PH_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase <= PH_HOLD;
		end else begin
			phase <= next_phase;
		end
	end
	// Settling count restarts whenever reset is requested again.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settleCount <= '0;
		end else if (!holdReset || coreResetReq) begin
			settleCount <= '0;
		end else if (settleCount != SETTLE_LAST) begin
			settleCount <= settleCount + 2'h1;
		end
	end
	// Program counter is cleared in every cycle outside RUN, so the first fetch is from address zero.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			programCounter <= '0;
		end else if (!coreRun) begin
			programCounter <= '0;
		end else if (instrStep) begin
			programCounter <= programCounter + PC_WIDTH'(1);
		end
	end
	// Control words; the HOLD phase wins over a software write, while SAMPLE accepts writes.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sysCtrlStatus <= SCS_RESET;
			irqCfg <= IRQ_CFG_RESET;
			clkPinCfg <= CLKPIN_RESET;
		end else if (holdReset) begin
			sysCtrlStatus <= SCS_RESET;
			irqCfg <= IRQ_CFG_RESET;
			clkPinCfg <= CLKPIN_RESET;
		end else begin
			if (sysCtrlWrEn) begin
				sysCtrlStatus <= sysCtrlWrData;
			end
			if (irqCfgWrEn) begin
				irqCfg <= irqCfgWrData;
			end
			if (clkPinWrEn) begin
				clkPinCfg <= clkPinWrData;
			end
		end
	end
	// Second status word; the boot bit is loaded only from the strap and ignores writes.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sysCtrlStatusTwo <= SCS2_RESET;
		end else if (holdReset) begin
			sysCtrlStatusTwo <= SCS2_RESET;
		end else if (phase == PH_SAMPLE) begin
			sysCtrlStatusTwo[BOOT_EN_BIT] <= pinLevel[PIN_BOOT];
		end else if (sysCtrlTwoWrEn) begin
			sysCtrlStatusTwo <= sysCtrlTwoWrData;
			sysCtrlStatusTwo[BOOT_EN_BIT] <= sysCtrlStatusTwo[BOOT_EN_BIT];
		end
	end
	// Protection latches: a new fault in the clear cycle wins, so no fault is lost.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			protectAFlag <= 1'b0;
			protectBFlag <= 1'b0;
		end else begin
			if (pinFall[PIN_PROT_A]) begin
				protectAFlag <= 1'b1;
			end else if (protectAClear || holdReset) begin
				protectAFlag <= 1'b0;
			end
			if (pinFall[PIN_PROT_B]) begin
				protectBFlag <= 1'b1;
			end else if (protectBClear || holdReset) begin
				protectBFlag <= 1'b0;
			end
		end
	end
	// Interrupt events come straight from the synchroniser's edge flops.
	assign protectAIrq = pinFall[PIN_PROT_A];
	assign protectBIrq = pinFall[PIN_PROT_B];
	assign pwmAHiZ = protectAFlag | outputDisable;
	assign pwmBHiZ = protectBFlag | outputDisable;
	// External interrupts: polarity bit set selects the rising edge, clear the falling.
	assign edgeOne = irqCfg[IRQ_ONE_POL_BIT] ? pinRise[PIN_IRQ_ONE] : pinFall[PIN_IRQ_ONE];
	assign edgeTwo = irqCfg[IRQ_TWO_POL_BIT] ? pinRise[PIN_IRQ_TWO] : pinFall[PIN_IRQ_TWO];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			extIrqOne <= 1'b0;
			extIrqTwo <= 1'b0;
			convStart <= 1'b0;
		end else begin
			extIrqOne <= coreRun & edgeOne;
			extIrqTwo <= coreRun & edgeTwo;
			convStart <= coreRun & edgeTwo & irqCfg[CONV_EN_BIT];
		end
	end
	// Both interrupt pins stay readable as GPIO inputs.
	assign extIrqOneLevel = pinLevel[PIN_IRQ_ONE];
	assign extIrqTwoLevel = pinLevel[PIN_IRQ_TWO];
	// Clock pin mux is combinational, since a flop at the system rate would destroy the clock.
	assign cpuClockOut = clkPinCfg[CLKPIN_CLOCK_BIT]
		? (sysCtrlStatus[CLK_SRC_BIT] ? dogTimerClockIn : cpuClockIn)
		: clkPinCfg[CLKPIN_DATA_BIT];
	assign cpuClockOeN = ~(clkPinCfg[CLKPIN_CLOCK_BIT] | clkPinCfg[CLKPIN_DIR_BIT]) | outputDisable;
	assign clkPinLevel = pinLevel[PIN_CLK_IO];
	// Flag value returns high on every reset and is software driven after.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flagValue <= FLAG_RESET;
		end else if (!coreRun) begin
			flagValue <= FLAG_RESET;
		end else if (flagWrEn) begin
			flagValue <= flagWrData;
		end
	end
	// The boot pin is an input during reset and the flag output once running.
	assign extFlagOut = flagValue;
	assign extFlagOeN = ~coreRun | outputDisable;
	// Output disable needs all three test conditions at once.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			outputDisable <= 1'b0;
		end else begin
			outputDisable <= ~pinLevel[PIN_OFF] & ~pinLevel[PIN_TRST] & pinLevel[PIN_EMULATOR_PIN_ZERO];
		end
	end

	assign xtalOutOeN = outputDisable;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence dogFire; dogOverflow && !dogActive; endsequence
	sequence dogPulse; dogActive [*8] ##1 dogActive ##1 dogActive ##1 !dogActive; endsequence
	a_pc_held_zero: assert property (!coreRun |=> programCounter == '0)
		else $error("program counter not zero after a reset cycle");
	a_run_from_zero: assert property ($rose(coreRun) |-> programCounter == '0 && $past(phase) == PH_SAMPLE)
		else $error("core did not start at address zero after sampling");
	a_regs_reset: assert property (holdReset |=> sysCtrlStatus == SCS_RESET && clkPinCfg == CLKPIN_RESET)
		else $error("control words not back at reset values");
	a_dog_length: assert property (dogFire |=> dogPulse)
		else $error("watchdog reset pulse has wrong length");
	a_dog_pin: assert property (dogActive && !outputDisable |-> !sysResetNPinOeN && !sysResetNPinOut)
		else $error("watchdog pulse not driven on the reset pin");
	a_prot_a_float: assert property (pinFall[PIN_PROT_A] |-> protectAIrq ##1 pwmAHiZ)
		else $error("protection A fault did not float group A");
	a_prot_b_float: assert property (pinFall[PIN_PROT_B] |-> protectBIrq ##1 pwmBHiZ)
		else $error("protection B fault did not float group B");
	a_irq_polarity: assert property (coreRun && (irqCfg[IRQ_ONE_POL_BIT] ? pinRise[PIN_IRQ_ONE] : pinFall[PIN_IRQ_ONE]) |=> extIrqOne)
		else $error("interrupt one missed its selected edge");
	a_conv_start: assert property (convStart |-> extIrqTwo && $past(irqCfg[CONV_EN_BIT]))
		else $error("conversion start without an enabled interrupt two edge");
	a_clock_mux: assert property (clkPinCfg[CLKPIN_CLOCK_BIT] && !outputDisable |-> !cpuClockOeN && cpuClockOut == (sysCtrlStatus[CLK_SRC_BIT] ? dogTimerClockIn : cpuClockIn))
		else $error("clock pin carries the wrong clock");
	a_gpio_input: assert property (holdReset |=> cpuClockOeN)
		else $error("clock pin driven while configured as input");
	a_boot_sample: assert property (phase == PH_SAMPLE |=> sysCtrlStatusTwo[BOOT_EN_BIT] == $past(pinLevel[PIN_BOOT]))
		else $error("boot strap not captured");
	a_flag_high: assert property ($rose(coreRun) && !outputDisable |-> extFlagOut && !extFlagOeN)
		else $error("flag not driven high after reset");
	a_off_float: assert property (outputDisable |-> xtalOutOeN && extFlagOeN && cpuClockOeN && sysResetNPinOeN && pwmAHiZ)
		else $error("a driver stayed on in the output-disable state");
	a_off_cause: assert property (outputDisable |-> $past(!pinLevel[PIN_OFF] && !pinLevel[PIN_TRST] && pinLevel[PIN_EMULATOR_PIN_ZERO]))
		else $error("output disable without all three conditions");
	a_one_cycle: assert property (protectAIrq |=> !protectAIrq)
		else $error("protection event longer than one cycle");
endmodule : spc_pin_ctrl
`default_nettype wire

// ### core/spc_pin_sync.sv
// Three-stage pin synchroniser with a settled level and one-cycle edge pulses.
// Assumes asynchronous pins; a change counts once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module spc_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] stageOne;
	logic [WIDTH-1:0] stageTwo;
	logic [WIDTH-1:0] stageThree;
	logic [WIDTH-1:0] next_level;

	// The first stage feeds only the second, so metastability has a full cycle to resolve.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stageOne <= IDLE;
			stageTwo <= IDLE;
			stageThree <= IDLE;
		end else begin
			stageOne <= pinIn;
			stageTwo <= stageOne;
			stageThree <= stageTwo;
		end
	end

	// A bit moves only when the two later stages agree, which rejects one-cycle glitches.
	assign next_level = (~(stageTwo ^ stageThree) & stageThree) | ((stageTwo ^ stageThree) & level);

	// Settled level and edges, each edge a single-cycle pulse.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level <= IDLE;
			rise <= '0;
			fall <= '0;
		end else begin
			level <= next_level;
			rise <= next_level & ~level;
			fall <= ~next_level & level;
		end
	end
endmodule : spc_pin_sync
`default_nettype wire

// ### core/spc_pkg.sv
// Shared constants and types for the system pin control block.
// Assumes a single 10 MHz system clock; all timing is counted in its cycles.
package spc_pkg;

	// Clock rate and the watchdog reset pulse, with its length in cycles rounded up.
	localparam int CLK_PERIOD_NS = 100;
	localparam int DOG_PULSE_NS = 1000;
	localparam int DOG_PULSE_CYCLES = (DOG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Cycles spent in reset after release so that the pin synchronisers settle.
	localparam int SYNC_SETTLE_CYCLES = 3;

	// Field positions in the control and status words.
	localparam int CLK_SRC_BIT = 14;
	localparam int BOOT_EN_BIT = 3;
	localparam int IRQ_ONE_POL_BIT = 0;
	localparam int IRQ_TWO_POL_BIT = 1;
	localparam int CONV_EN_BIT = 2;
	localparam int CLKPIN_CLOCK_BIT = 0;
	localparam int CLKPIN_DIR_BIT = 1;
	localparam int CLKPIN_DATA_BIT = 2;

	// Values after reset.
	localparam logic [15:0] SCS_RESET = 16'h0000;
	localparam logic [15:0] SCS2_RESET = 16'h0000;
	localparam logic [2:0] IRQ_CFG_RESET = 3'h0;
	localparam logic [2:0] CLKPIN_RESET = 3'h0;
	localparam logic FLAG_RESET = 1'b1;

	// Positions of the synchronised pins in one vector, and their idle levels.
	localparam int PIN_RESET = 0;
	localparam int PIN_PROT_A = 1;
	localparam int PIN_PROT_B = 2;
	localparam int PIN_IRQ_ONE = 3;
	localparam int PIN_IRQ_TWO = 4;
	localparam int PIN_BOOT = 5;
	localparam int PIN_OFF = 6;
	localparam int PIN_TRST = 7;
	localparam int PIN_EMULATOR_PIN_ZERO = 8;
	localparam int PIN_CLK_IO = 9;
	localparam int PIN_COUNT = 10;
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 10'h37F;

	// Core phase: held in reset, sampling straps, or running.
	typedef enum logic [2:0] {
		PH_HOLD = 3'b001,
		PH_SAMPLE = 3'b010,
		PH_RUN = 3'b100
	} spc_phase_type;

endpackage : spc_pkg

// ### test/spc_board_model.sv
// Board model for the pin control block: reset line, boot strap, clock pin and clock sources.
// Assumes the bench wires the device's pin outputs and enables straight to it.
`timescale 1ns/10ps
`default_nettype none
module spc_board_model (
	input wire logic boardResetN,
	input wire logic bootStrap,
	input wire logic boardClkPin,
	input wire logic sysResetNPinOut,
	input wire logic sysResetNPinOeN,
	input wire logic extFlagOut,
	input wire logic extFlagOeN,
	input wire logic cpuClockOut,
	input wire logic cpuClockOeN,
	output logic sysResetNPinIn,
	output logic bootEnPinIn,
	output logic clkPinIn,
	output var logic cpuClockIn,
	output var logic dogTimerClockIn
);
	// The reset line is open drain with a pull-up, so either party may pull it low.
	assign sysResetNPinIn = boardResetN & (sysResetNPinOeN | sysResetNPinOut);
	// The strap is a passive resistor, so the driven flag overrides it.
	assign bootEnPinIn = extFlagOeN ? bootStrap : extFlagOut;
	// The clock pin shows the board level only while the device leaves it floating.
	assign clkPinIn = cpuClockOeN ? boardClkPin : cpuClockOut;
	// Two clocks unrelated to the system clock, so the mux is seen at odd moments.
	initial cpuClockIn = 1'h0;
	always #17 cpuClockIn = ~cpuClockIn;
	initial dogTimerClockIn = 1'h0;
	always #61 dogTimerClockIn = ~dogTimerClockIn;
endmodule : spc_board_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the system pin control block.
// Assumes the board model supplies the shared pins and the two routed clocks.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_sys = 1'h0, rst = 1'h1, dogOverflow = 1'h0, instrStep = 1'h0;
	logic driveProtectAIn = 1'h1, driveProtectBIn = 1'h1, extIrqOneIn = 1'h1, extIrqTwoIn = 1'h1;
	logic protectAClear = 1'h0, protectBClear = 1'h0, irqCfgWrEn = 1'h0, sysCtrlWrEn = 1'h0;
	logic sysCtrlTwoWrEn = 1'h0, clkPinWrEn = 1'h0, flagWrEn = 1'h0, flagWrData = 1'h0;
	logic [2:0] irqCfgWrData = 3'h0, clkPinWrData = 3'h0;
	logic [15:0] sysCtrlWrData = 16'h0000, sysCtrlTwoWrData = 16'h0000;
	logic outputDisablePinIn = 1'h1, trstIn = 1'h0, emulatorPinZeroIn = 1'h1;
	logic boardResetN = 1'h1, bootStrap = 1'h1, boardClkPin = 1'h1;
	logic sysResetNPinOut, sysResetNPinOeN, coreHalt, protectAIrq, protectBIrq, pwmAHiZ, pwmBHiZ;
	logic extIrqOne, extIrqTwo, convStart, extIrqOneLevel, extIrqTwoLevel, cpuClockOut, cpuClockOeN;
	logic clkPinLevel, extFlagOut, extFlagOeN, outputDisable, xtalOutOeN;
	logic sysResetNPinIn, bootEnPinIn, clkPinIn, cpuClockIn, dogTimerClockIn;
	logic [15:0] programCounter, sysCtrlStatus, sysCtrlStatusTwo;
	logic [2:0] irqCfg, clkPinCfg;
	logic [4:0] pulses;
	logic [15:0] cnt [5];
	logic [2:0] odPat [6] = '{3'h5, 3'h1, 3'h3, 3'h1, 3'h0, 3'h5};
	int err_count = 0;
	int n_checks = 0;

	spc_pin_ctrl #(.DOG_CYCLES(10)) i_spc_pin_ctrl (.*);
	spc_board_model i_spc_board_model (.*);

	// System clock at 10 MHz.
	always #50 clk_sys = ~clk_sys;

	// Count every event pulse so that a pulse lasting two cycles is caught as a double.
	assign pulses = {convStart, extIrqTwo, extIrqOne, protectBIrq, protectAIrq};
	always @(posedge clk_sys) begin
		foreach (cnt[k]) cnt[k] <= cnt[k] + 16'(pulses[k]);
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task final_report();
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Inputs always change a fixed 10 ns after the rising edge.
	task tick(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask : tick

	// One-cycle write strobe; sel 0 interrupt config, 1 control word, 2 clock pin, 3 flag, 4 second status word.
	// An idle cycle follows, so a second write never reassigns the strobes in the same time step.
	task wr(input int sel, input logic [15:0] d);
		{irqCfgWrData, sysCtrlWrData, clkPinWrData, flagWrData, sysCtrlTwoWrData} = {d[2:0], d, d[2:0], d[0], d};
		{irqCfgWrEn, sysCtrlWrEn, clkPinWrEn, flagWrEn, sysCtrlTwoWrEn} = 5'h10 >> sel;
		tick();
		{irqCfgWrEn, sysCtrlWrEn, clkPinWrEn, flagWrEn, sysCtrlTwoWrEn} = 5'h00;
		tick();
	endtask : wr

	// Waits a bounded time for the core to leave reset.
	task waitRun();
		int i;
		for (i = 0; i < 20 && coreHalt !== 1'h0; i++) tick();
		check(coreHalt, 0);
	endtask : waitRun

	// Sets {protect A, protect B, irq one, irq two}, then counts events over eight cycles.
	task pins(input logic [3:0] v, input logic [4:0] exp);
		{driveProtectAIn, driveProtectBIn, extIrqOneIn, extIrqTwoIn} = v;
		foreach (cnt[k]) cnt[k] = 16'h0000;
		tick(8);
		foreach (cnt[k]) check(cnt[k], 16'(exp[k]));
	endtask : pins

	// Follows the clock pin across several edges of the selected source.
	task clkChk(input bit dog);
		repeat (3) begin
			if (dog) @(dogTimerClockIn);
			else @(cpuClockIn);
			#1;
			check(cpuClockOut, dog ? dogTimerClockIn : cpuClockIn);
		end
		// Back onto the stimulus grid before anything else is driven.
		tick();
	endtask : clkChk

	initial begin
		// Values held while reset is applied.
		tick();
		check(coreHalt, 1);
		check(programCounter, 0);
		check({sysCtrlStatus, irqCfg, clkPinCfg}, 0);
		check({cpuClockOeN, extFlagOeN, sysResetNPinOeN}, 3'h7);
		@(posedge clk_sys);
		#10 rst = 1'h0;
		waitRun();
		check(sysCtrlStatusTwo[3], 1);
		check({extFlagOut, extFlagOeN}, 2'h2);
		check(programCounter, 0);
		instrStep = 1'h1;
		tick(3);
		instrStep = 1'h0;
		check(programCounter, 16'h0003);
		wr(3, 0);
		check(extFlagOut, 0);
		// Clock pin: watchdog clock, CPU clock, then general-purpose use.
		wr(1, 16'h4000);
		check(sysCtrlStatus, 16'h4000);
		wr(2, 1);
		check(cpuClockOeN, 0);
		clkChk(1'b1);
		wr(1, 0);
		clkChk(1'b0);
		wr(2, 0);
		check(cpuClockOeN, 1);
		boardClkPin = 1'h0;
		tick(5);
		check(clkPinLevel, 0);
		wr(2, 6);
		check({cpuClockOeN, cpuClockOut}, 2'h1);
		// Watchdog pulse, with a second overflow in mid-pulse that must be ignored.
		bootStrap = 1'h0;
		dogOverflow = 1'h1;
		tick();
		for (int i = 0; i < 10; i++) begin
			check({sysResetNPinOeN, sysResetNPinOut, sysResetNPinIn}, 0);
			dogOverflow = (i == 3);
			tick();
		end
		check(sysResetNPinOeN, 1);
		check({coreHalt, programCounter}, 17'h10000);
		waitRun();
		check(sysCtrlStatusTwo[3], 0);
		wr(4, 16'hFFFF);
		check(sysCtrlStatusTwo, 16'hFFF7);
		check({clkPinCfg, cpuClockOeN}, 4'h1);
		check(extFlagOut, 1);
		// Each protection fault floats only its own PWM group until cleared.
		for (int g = 0; g < 2; g++) begin
			pins(4'hF ^ (4'h8 >> g), 5'h01 << g);
			check({pwmAHiZ, pwmBHiZ}, 2'h2 >> g);
			{protectAClear, protectBClear} = 2'h2 >> g;
			tick();
			{protectAClear, protectBClear} = 2'h0;
			pins(4'hF, 0);
			check({pwmAHiZ, pwmBHiZ}, 0);
		end
		// Rising then falling polarity; a falling edge under rising polarity must stay silent.
		for (int p = 1; p >= 0; p--) begin
			wr(0, 16'({p[0], p[0], p[0]}));
			check(irqCfg, {p[0], p[0], p[0]});
			pins({2'h3, ~p[0], ~p[0]}, 0);
			pins({2'h3, p[0], p[0]}, {p[0], 4'hC});
			check({extIrqOneLevel, extIrqTwoLevel}, {p[0], p[0]});
		end
		pins(4'hF, 0);
		// Only the full combination of the three test pins floats the drivers.
		wr(2, 1);
		foreach (odPat[k]) begin
			{outputDisablePinIn, trstIn, emulatorPinZeroIn} = odPat[k];
			tick(8);
			check({outputDisable, xtalOutOeN, pwmAHiZ, pwmBHiZ, extFlagOeN, cpuClockOeN},
				{6{odPat[k] == 3'h1}});
		end
		final_report();
	end

	// A hang is cut short well beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		err_count++;
		final_report();
	end
endmodule : testbench
`default_nettype wire
